// ### hdl/bpd_pin_mux.sv
// per-pin ownership selection and registered pin drivers
`timescale 1ns/100ps
module bpd_pin_mux (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire bpd_pkg::bpd_mux_ctrl_type ctrl_i,
    output logic [bpd_pkg::PORT_WIDTH-1:0] pin_o,
    output logic [bpd_pkg::PORT_WIDTH-1:0] pin_oe_o
);
    import bpd_pkg::*;

    logic [PORT_WIDTH-1:0] data_d;
    logic [PORT_WIDTH-1:0] oe_d;
    logic [PORT_WIDTH-1:0] data_q;
    logic [PORT_WIDTH-1:0] oe_q;

    genvar i;
    generate
        for (i = 0; i < PORT_WIDTH; i++) begin : g_pin
            wire logic port_drive = !ctrl_i.direction[i];
            wire logic slave_drive = ctrl_i.slave_read;
            if (i >= PWM_FIRST_PIN) begin : g_pwm
                // pwm owns the pin only with its direction bit at zero
                wire logic pwm_own = ctrl_i.pwm_enable[i-PWM_FIRST_PIN] && !ctrl_i.direction[i];
                assign data_d[i] = pwm_own ? ctrl_i.pwm_level[i-PWM_FIRST_PIN] : ctrl_i.latch[i];
                assign oe_d[i] = pwm_own ? !ctrl_i.pwm_tristate :
                                 ctrl_i.slave_mode ? slave_drive : port_drive;
            end else begin : g_plain
                assign data_d[i] = ctrl_i.latch[i];
                assign oe_d[i] = ctrl_i.slave_mode ? slave_drive : port_drive;
            end
        end
    endgenerate

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            data_q <= '0;
            oe_q <= '0;
        end else begin
            data_q <= data_d;
            oe_q <= oe_d;
        end
    end

    assign pin_o = data_q;
    assign pin_oe_o = oe_q;

endmodule : bpd_pin_mux

// ### hdl/bpd_pkg.sv
// constants, register map and carrier types of the bidirectional port d block
package bpd_pkg;

    localparam int PORT_WIDTH = 8;
    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 32;
    localparam int PWM_CHANNELS = 3;

    // register byte offsets
    localparam logic [ADDR_WIDTH-1:0] OFF_PIN_LEVELS = 8'h00;
    localparam logic [ADDR_WIDTH-1:0] OFF_OUTPUT_LATCH = 8'h04;
    localparam logic [ADDR_WIDTH-1:0] OFF_DIRECTION = 8'h08;
    localparam logic [ADDR_WIDTH-1:0] OFF_PORT_E_DIR = 8'h0C;
    localparam logic [ADDR_WIDTH-1:0] OFF_PWM_CTRL = 8'h10;
    localparam logic [ADDR_WIDTH-1:0] OFF_PWM_PIN_CFG = 8'h14;

    // reset values
    localparam logic [PORT_WIDTH-1:0] RESET_LATCH = 8'h00;
    localparam logic [PORT_WIDTH-1:0] RESET_DIRECTION = 8'hFF;
    localparam logic [PORT_WIDTH-1:0] RESET_PORT_E_DIR = 8'h07;
    localparam logic [PORT_WIDTH-1:0] RESET_PWM_CTRL = 8'h00;
    localparam logic [PORT_WIDTH-1:0] RESET_PWM_PIN_CFG = 8'h00;

    // port e direction and slave status fields
    localparam int SLAVE_IN_FULL_BIT = 7;
    localparam int SLAVE_OUT_FULL_BIT = 6;
    localparam int SLAVE_OVERFLOW_BIT = 5;
    localparam int SLAVE_MODE_BIT = 4;
    localparam int PORT_E_DIR_MSB = 2;
    localparam logic [PORT_WIDTH-1:0] PORT_E_WRITE_MASK = 8'h37;

    // pwm capture control fields and the pwm pin config shutdown bit
    localparam int PWM_CFG_HI_BIT = 7;
    localparam int PWM_CFG_LO_BIT = 6;
    localparam int PWM_MODE_HI_BIT = 3;
    localparam int PWM_MODE_LO_BIT = 2;
    localparam logic [1:0] PWM_MODE_CODE = 2'h3;
    localparam logic [1:0] PWM_CFG_SINGLE = 2'h0;
    localparam int SHUTDOWN_TRI_BIT = 0;

    // lowest pin that carries a pwm channel (b on 5, c on 6, d on 7)
    localparam int PWM_FIRST_PIN = 5;

    typedef struct packed {
        logic [PWM_CHANNELS-1:0] level;
        logic shutdown;
    } bpd_pwm_type;

    typedef struct packed {
        logic [PORT_WIDTH-1:0] latch;
        logic [PORT_WIDTH-1:0] direction;
        logic slave_mode;
        logic slave_read;
        logic [PWM_CHANNELS-1:0] pwm_enable;
        logic [PWM_CHANNELS-1:0] pwm_level;
        logic pwm_tristate;
    } bpd_mux_ctrl_type;

    typedef enum logic {
        BPD_APB_IDLE,
        BPD_APB_ANSWER
    } bpd_apb_state_type;

endpackage : bpd_pkg

// ### hdl/bpd_port.sv
// bidirectional port d with slave-port and pwm pin sharing, apb registers
//
// Functional notes
// - eight two-way pins, each with its own direction bit
// - direction bit one releases the pin, making it an input
// - direction bit zero drives the pin from the output latch
// - latch register reads back latch contents, not pin levels
// - after reset every pin, pwm pins too, is an input
// - mode select bit 4 of port e register turns port into slave bus
// - slave mode ignores direction; external reads drive latch, writes are inputs
// - dual or quad pwm output forces slave-port functions off
// - pins 5,6,7 carry pwm b,c,d over latch and slave data
// - pwm pins may be released during a pwm shutdown event
// - mode select one means slave port, zero means plain port
`timescale 1ns/100ps
module bpd_port (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [bpd_pkg::ADDR_WIDTH-1:0] paddr_i,
    input wire logic [bpd_pkg::DATA_WIDTH-1:0] pwdata_i,
    output logic [bpd_pkg::DATA_WIDTH-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [bpd_pkg::PORT_WIDTH-1:0] pin_i,
    output logic [bpd_pkg::PORT_WIDTH-1:0] pin_o,
    output logic [bpd_pkg::PORT_WIDTH-1:0] pin_oe_o,
    input wire logic slave_read_i,
    input wire logic slave_in_full_i,
    input wire logic slave_out_full_i,
    input wire logic slave_overflow_i,
    input wire bpd_pkg::bpd_pwm_type pwm_i,
    output logic slave_port_enable_o,
    output logic [bpd_pkg::PORT_E_DIR_MSB:0] port_e_direction_o,
    output logic [bpd_pkg::PORT_WIDTH-1:0] pwm_capture_control_o
);
    import bpd_pkg::*;

    function automatic logic reg_hit(input logic [ADDR_WIDTH-1:0] addr, input logic [ADDR_WIDTH-1:0] offset);
        reg_hit = (addr == offset);
    endfunction : reg_hit

    // ---- apb slave: one wait cycle so read data leave a flip-flop ----
    bpd_apb_state_type state_q;
    bpd_apb_state_type state_d;
    logic [DATA_WIDTH-1:0] prdata_q;
    logic pslverr_q;

    wire logic access = psel_i && penable_i;
    wire logic commit = access && (state_q == BPD_APB_ANSWER);
    wire logic capture = access && (state_q == BPD_APB_IDLE);

    always_comb begin
        state_d = state_q;
        case (state_q)
            BPD_APB_IDLE: begin
                if (access) begin
                    state_d = BPD_APB_ANSWER;
                end
            end
            BPD_APB_ANSWER: begin
                state_d = BPD_APB_IDLE;
            end
            default: begin
                state_d = BPD_APB_IDLE;
            end
        endcase
    end

    wire logic hit_pins = reg_hit(paddr_i, OFF_PIN_LEVELS);
    wire logic hit_latch = reg_hit(paddr_i, OFF_OUTPUT_LATCH);
    wire logic hit_dir = reg_hit(paddr_i, OFF_DIRECTION);
    wire logic hit_port_e = reg_hit(paddr_i, OFF_PORT_E_DIR);
    wire logic hit_pwm = reg_hit(paddr_i, OFF_PWM_CTRL);
    wire logic hit_pwm_pin = reg_hit(paddr_i, OFF_PWM_PIN_CFG);
    wire logic hit_any = hit_pins || hit_latch || hit_dir || hit_port_e || hit_pwm || hit_pwm_pin;

    wire logic wr_commit = commit && pwrite_i && hit_any;
    wire logic [PORT_WIDTH-1:0] wbyte = pwdata_i[PORT_WIDTH-1:0];

    // ---- registers ----
    logic [PORT_WIDTH-1:0] latch_q;
    logic [PORT_WIDTH-1:0] dir_q;
    logic [PORT_WIDTH-1:0] port_e_q;
    logic [PORT_WIDTH-1:0] pwm_ctrl_q;
    logic [PORT_WIDTH-1:0] pwm_pin_q;
    logic overflow_q;
    logic [PORT_WIDTH-1:0] pin_levels;

    // either the latch or the pin-level register loads the latch
    wire logic latch_we = wr_commit && (hit_latch || hit_pins);
    wire logic dir_we = wr_commit && hit_dir;
    wire logic port_e_we = wr_commit && hit_port_e;
    wire logic pwm_we = wr_commit && hit_pwm;
    wire logic pwm_pin_we = wr_commit && hit_pwm_pin;

    // full status bits 7 and 6 are read-only; only the mask bits take the write
    wire logic [PORT_WIDTH-1:0] port_e_wr = (port_e_q & ~PORT_E_WRITE_MASK) | (wbyte & PORT_E_WRITE_MASK);

    // overflow: hardware set wins over a software clear in the same cycle
    wire logic overflow_sw = port_e_we ? wbyte[SLAVE_OVERFLOW_BIT] : overflow_q;
    wire logic overflow_d = overflow_sw || slave_overflow_i;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_q <= BPD_APB_IDLE;
            latch_q <= RESET_LATCH;
            dir_q <= RESET_DIRECTION;
            port_e_q <= RESET_PORT_E_DIR;
            pwm_ctrl_q <= RESET_PWM_CTRL;
            pwm_pin_q <= RESET_PWM_PIN_CFG;
            overflow_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (latch_we) begin
                latch_q <= wbyte;
            end
            if (dir_we) begin
                dir_q <= wbyte;
            end
            if (port_e_we) begin
                port_e_q <= port_e_wr;
            end
            if (pwm_we) begin
                pwm_ctrl_q <= wbyte;
            end
            if (pwm_pin_we) begin
                pwm_pin_q <= wbyte;
            end
            overflow_q <= overflow_d;
        end
    end

    // ---- read path ----
    wire logic [PORT_WIDTH-1:0] port_e_view = {slave_in_full_i, slave_out_full_i, overflow_q,
        port_e_q[SLAVE_MODE_BIT], 1'b0, port_e_q[PORT_E_DIR_MSB:0]};

    logic [PORT_WIDTH-1:0] rd_byte;
    assign rd_byte = hit_pins ? pin_levels :
                     hit_latch ? latch_q :
                     hit_dir ? dir_q :
                     hit_port_e ? port_e_view :
                     hit_pwm ? pwm_ctrl_q :
                     hit_pwm_pin ? pwm_pin_q : '0;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else if (capture) begin
            prdata_q <= {{(DATA_WIDTH-PORT_WIDTH){1'b0}}, rd_byte};
            pslverr_q <= !hit_any;
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = (state_q == BPD_APB_ANSWER);
    assign pslverr_o = pready_o && pslverr_q;

    // ---- pin inputs ----
    bpd_sync u_sync (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .async_i(pin_i),
        .sync_o(pin_levels)
    );

    // ---- ownership decisions ----
    wire logic [1:0] pwm_mode = {pwm_ctrl_q[PWM_MODE_HI_BIT], pwm_ctrl_q[PWM_MODE_LO_BIT]};
    wire logic [1:0] pwm_cfg = {pwm_ctrl_q[PWM_CFG_HI_BIT], pwm_ctrl_q[PWM_CFG_LO_BIT]};
    wire logic pwm_active = (pwm_mode == PWM_MODE_CODE);
    // half-bridge uses b only; full-bridge codes have the low bit set and use b, c, d
    wire logic pwm_multi = pwm_active && (pwm_cfg != PWM_CFG_SINGLE);
    wire logic pwm_quad = pwm_active && pwm_cfg[0];
    wire logic [PWM_CHANNELS-1:0] pwm_enable = {pwm_quad, pwm_quad, pwm_multi};

    wire logic mode_select = port_e_q[SLAVE_MODE_BIT];
    wire logic slave_mode = mode_select && !pwm_multi;
    wire logic pwm_tristate = pwm_i.shutdown && pwm_pin_q[SHUTDOWN_TRI_BIT];

    bpd_mux_ctrl_type mux_ctrl;
    assign mux_ctrl.latch = latch_q;
    assign mux_ctrl.direction = dir_q;
    assign mux_ctrl.slave_mode = slave_mode;
    assign mux_ctrl.slave_read = slave_mode && slave_read_i;
    assign mux_ctrl.pwm_enable = pwm_enable;
    assign mux_ctrl.pwm_level = pwm_i.level;
    assign mux_ctrl.pwm_tristate = pwm_tristate;

    bpd_pin_mux u_mux (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .ctrl_i(mux_ctrl),
        .pin_o(pin_o),
        .pin_oe_o(pin_oe_o)
    );

    assign slave_port_enable_o = slave_mode;
    assign port_e_direction_o = port_e_q[PORT_E_DIR_MSB:0];
    assign pwm_capture_control_o = pwm_ctrl_q;

    // ---- assertions ----
    sequence s_latch_written;
        latch_we ##1 1'b1;
    endsequence

    sequence s_pin_plain_out(int k);
        !slave_mode && !dir_q[k];
    endsequence

    // a pin with direction one and no owner is released on the next edge
    property p_plain_input;
        @(posedge clock_i) disable iff (reset_i)
        (!slave_mode && dir_q[0]) |=> !pin_oe_o[0];
    endproperty
    a_dir_input_release: assert property (p_plain_input)
        else $error("pin with direction one is being driven");

    property p_plain_output;
        @(posedge clock_i) disable iff (reset_i)
        s_pin_plain_out(1) |=> (pin_oe_o[1] && pin_o[1] == $past(latch_q[1]));
    endproperty
    a_dir_output_drive: assert property (p_plain_output)
        else $error("output pin does not follow the latch");

    a_latch_read_back: assert property (@(posedge clock_i) disable iff (reset_i)
        (capture && hit_latch) |=> (prdata_o[PORT_WIDTH-1:0] == latch_q && pready_o))
        else $error("latch read does not return latch contents");

    a_pins_read_levels: assert property (@(posedge clock_i) disable iff (reset_i)
        (capture && hit_pins) |=> (prdata_o[PORT_WIDTH-1:0] == $past(pin_levels)))
        else $error("pin register read does not return pin levels");

    a_pins_write_latch: assert property (@(posedge clock_i) disable iff (reset_i)
        (latch_we && hit_pins) ##0 s_latch_written |-> latch_q == $past(wbyte))
        else $error("pin register write did not load the latch");

    a_reset_inputs: assert property (@(posedge clock_i)
        $fell(reset_i) |-> (pin_oe_o == '0 && dir_q == RESET_DIRECTION) [*2])
        else $error("pins not inputs after reset");

    a_pwm_blocks_slave: assert property (@(posedge clock_i) disable iff (reset_i)
        pwm_multi |-> !slave_port_enable_o)
        else $error("slave port left on during multi-output pwm");

    a_slave_mode_bit: assert property (@(posedge clock_i) disable iff (reset_i)
        (!pwm_multi && port_e_we) |=> (slave_port_enable_o == $past(wbyte[SLAVE_MODE_BIT])))
        else $error("mode select bit does not steer slave mode");

    a_slave_read_drive: assert property (@(posedge clock_i) disable iff (reset_i)
        (slave_mode && slave_read_i && !pwm_multi) |=> (pin_oe_o[3:0] == 4'hF && pin_o[0] == $past(latch_q[0])))
        else $error("external read does not drive latch data");

    a_slave_idle_float: assert property (@(posedge clock_i) disable iff (reset_i)
        (slave_mode && !slave_read_i) |=> (pin_oe_o == '0))
        else $error("slave port drives pins without an external read");

    a_pwm_priority: assert property (@(posedge clock_i) disable iff (reset_i)
        (pwm_multi && !dir_q[PWM_FIRST_PIN] && !pwm_tristate)
        |=> (pin_oe_o[PWM_FIRST_PIN] && pin_o[PWM_FIRST_PIN] == $past(pwm_i.level[0])))
        else $error("pwm channel b does not own its pin");

    a_pwm_shutdown: assert property (@(posedge clock_i) disable iff (reset_i)
        (pwm_quad && pwm_tristate && !dir_q[PWM_FIRST_PIN+2]) |=> !pin_oe_o[PWM_FIRST_PIN+2])
        else $error("pwm pin still driven during shutdown");

    a_apb_one_wait: assert property (@(posedge clock_i) disable iff (reset_i)
        capture |=> pready_o ##1 !pready_o)
        else $error("apb answer not in the second access cycle");

    a_overflow_set_wins: assert property (@(posedge clock_i) disable iff (reset_i)
        slave_overflow_i |=> overflow_q)
        else $error("overflow event lost");

    // apb phases as the master presents them
    sequence s_apb_setup;
        psel_i && !penable_i;
    endsequence

    sequence s_apb_access;
        psel_i && penable_i;
    endsequence

    a_setup_no_ready: assert property (@(posedge clock_i) disable iff (reset_i)
        s_apb_setup |-> !pready_o)
        else $error("ready raised in a setup cycle");

    a_apb_answer_time: assert property (@(posedge clock_i) disable iff (reset_i)
        s_apb_setup ##1 s_apb_access |=> pready_o)
        else $error("ready missing one cycle into the access phase");

    a_unmapped_error: assert property (@(posedge clock_i) disable iff (reset_i)
        (capture && !hit_any) |=> (pslverr_o && prdata_o == '0))
        else $error("unmapped access not refused");

    a_unmapped_write_ignored: assert property (@(posedge clock_i) disable iff (reset_i)
        (commit && pwrite_i && !hit_any) |=> ($stable(latch_q) && $stable(dir_q) && $stable(port_e_q)))
        else $error("unmapped write changed a register");

    a_latch_write_land: assert property (@(posedge clock_i) disable iff (reset_i)
        latch_we |=> latch_q == $past(wbyte))
        else $error("latch write did not land");

    a_dir_write_land: assert property (@(posedge clock_i) disable iff (reset_i)
        dir_we |=> dir_q == $past(wbyte))
        else $error("direction write did not land");

    // every pin answers an external read, whatever its direction bit holds
    a_slave_dir_ignored: assert property (@(posedge clock_i) disable iff (reset_i)
        (slave_mode && slave_read_i) |=> (pin_oe_o == {PORT_WIDTH{1'b1}} && pin_o == $past(latch_q)))
        else $error("external read not driven on every pin");

    a_mode_bit_select: assert property (@(posedge clock_i) disable iff (reset_i)
        !pwm_multi |-> (slave_port_enable_o == port_e_q[SLAVE_MODE_BIT]))
        else $error("mode select bit and slave mode disagree");

    a_pwm_chan_c: assert property (@(posedge clock_i) disable iff (reset_i)
        (pwm_quad && !dir_q[PWM_FIRST_PIN+1] && !pwm_tristate)
        |=> (pin_oe_o[PWM_FIRST_PIN+1] && pin_o[PWM_FIRST_PIN+1] == $past(pwm_i.level[1])))
        else $error("pwm channel c does not own its pin");

    a_pwm_chan_d: assert property (@(posedge clock_i) disable iff (reset_i)
        (pwm_quad && !dir_q[PORT_WIDTH-1] && !pwm_tristate)
        |=> (pin_oe_o[PORT_WIDTH-1] && pin_o[PORT_WIDTH-1] == $past(pwm_i.level[PWM_CHANNELS-1])))
        else $error("pwm channel d does not own its pin");

    // half-bridge leaves c and d with the latch
    a_half_bridge_b_only: assert property (@(posedge clock_i) disable iff (reset_i)
        (pwm_multi && !pwm_quad && !dir_q[PWM_FIRST_PIN+1])
        |=> (pin_o[PWM_FIRST_PIN+1] == $past(latch_q[PWM_FIRST_PIN+1])))
        else $error("half-bridge took pin c");

    a_shutdown_hold: assert property (@(posedge clock_i) disable iff (reset_i)
        (pwm_multi && pwm_i.shutdown && !pwm_pin_q[SHUTDOWN_TRI_BIT] && !dir_q[PWM_FIRST_PIN])
        |=> pin_oe_o[PWM_FIRST_PIN])
        else $error("pwm pin released though shutdown release is off");

    a_reset_quiet: assert property (@(posedge clock_i)
        reset_i |=> (!pready_o && !pslverr_o && prdata_o == '0 && pin_o == '0 && pin_oe_o == '0))
        else $error("outputs not quiet after a reset edge");

    // the pin register lags the pads by the two synchroniser stages
    a_pin_sync_delay: assert property (@(posedge clock_i) disable iff (reset_i)
        1'b1 |-> ##2 (pin_levels == $past(pin_i, 2)))
        else $error("pin levels not two cycles behind the pads");

endmodule : bpd_port

// ### hdl/bpd_sync.sv
// two flip-flop synchroniser for the port pin levels
`timescale 1ns/100ps
module bpd_sync (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [bpd_pkg::PORT_WIDTH-1:0] async_i,
    output logic [bpd_pkg::PORT_WIDTH-1:0] sync_o
);
    import bpd_pkg::*;

    logic [PORT_WIDTH-1:0] meta_q;
    logic [PORT_WIDTH-1:0] sync_q;

    // first stage feeds only the second stage
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule : bpd_sync

// ### tb/bpd_pin_host.sv
// board side of the port pins: resolves the wire and feeds the pad inputs
`timescale 1ns/100ps
module bpd_pin_host (
    input wire logic clock_i,
    input wire logic [bpd_pkg::PORT_WIDTH-1:0] pin_o,
    input wire logic [bpd_pkg::PORT_WIDTH-1:0] pin_oe_o,
    input wire logic [bpd_pkg::PORT_WIDTH-1:0] host_data_i,
    input wire logic [bpd_pkg::PORT_WIDTH-1:0] host_oe_i,
    output logic [bpd_pkg::PORT_WIDTH-1:0] pin_i
);
    import bpd_pkg::*;
    logic [PORT_WIDTH-1:0] float_q = 8'h55;
    // no pull on these pins: an undriven line wanders every cycle
    always_ff @(posedge clock_i) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int i = 0; i < PORT_WIDTH; i++) begin
            if (pin_oe_o[i] && host_oe_i[i]) begin
                pin_i[i] = 1'bx;
            end else if (pin_oe_o[i]) begin
                pin_i[i] = pin_o[i];
            end else if (host_oe_i[i]) begin
                pin_i[i] = host_data_i[i];
            end else begin
                pin_i[i] = float_q[i];
            end
        end
    end
endmodule : bpd_pin_host

// ### tb/bpd_port_tb.sv
// self-checking testbench of the bidirectional port d block
`timescale 1ns/100ps
module bpd_port_tb;
    import bpd_pkg::*;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_WIDTH-1:0] paddr = 8'h00;
    logic [DATA_WIDTH-1:0] pwdata = 32'h0, prdata_o;
    logic pready_o, pslverr_o, slave_port_enable_o;
    logic [PORT_WIDTH-1:0] pin_i, pin_o, pin_oe_o, pwm_capture_control_o;
    logic [PORT_WIDTH-1:0] host_data = 8'h00, host_oe = 8'h00;
    logic slave_read = 1'b0, in_full = 1'b0, out_full = 1'b0, overflow = 1'b0;
    logic [PORT_E_DIR_MSB:0] port_e_direction_o;
    bpd_pwm_type pwm = '0;
    int fails = 0;
    int n_compared = 0;
    logic [31:0] rdat;
    logic rerr;

    always #20 clock_i = ~clock_i;

    bpd_port dut_u (.clock_i(clock_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .slave_read_i(slave_read), .slave_in_full_i(in_full),
        .slave_out_full_i(out_full), .slave_overflow_i(overflow), .pwm_i(pwm),
        .slave_port_enable_o(slave_port_enable_o), .port_e_direction_o(port_e_direction_o),
        .pwm_capture_control_o(pwm_capture_control_o));

    bpd_pin_host host_u (.clock_i(clock_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
        .host_data_i(host_data), .host_oe_i(host_oe), .pin_i(pin_i));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // holds the whole request until pready is seen high at a rising edge or 20 edges have passed
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clock_i);
        penable <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, pready_o, 1'b1);
        end
        rdat = prdata_o;
        rerr = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        chk(rdat, exp);
        chk(32'(rerr), 32'h0);
    endtask : rd_chk

    task automatic settle(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : settle

    task automatic t_reset;
        chk(32'(pin_oe_o), 32'h0);
        rd_chk(OFF_DIRECTION, 32'h000000FF);
        rd_chk(OFF_OUTPUT_LATCH, 32'h0);
        rd_chk(OFF_PORT_E_DIR, 32'h07);
        rd_chk(OFF_PWM_CTRL, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk({rdat[30:0], rerr}, 32'h1);
        apb(1'b1, 8'h18, 32'hFF);
        chk(32'(rerr), 32'h1);
        rd_chk(OFF_OUTPUT_LATCH, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_gpio;
        for (int i = 0; i < PORT_WIDTH; i++) begin
            apb(1'b1, OFF_DIRECTION, 32'(~(8'h01 << i)));
            settle(2);
            chk(32'(pin_oe_o), 32'(8'h01 << i));
        end
        @(posedge clock_i);
        host_data <= 8'h3C;
        host_oe <= 8'h0F;
        apb(1'b1, OFF_OUTPUT_LATCH, 32'hA5);
        apb(1'b1, OFF_DIRECTION, 32'h0F);
        settle(2);
        chk(32'(pin_oe_o), 32'hF0);
        chk(32'(pin_o & 8'hF0), 32'hA0);
        rd_chk(OFF_OUTPUT_LATCH, 32'hA5);
        rd_chk(OFF_PIN_LEVELS, 32'hAC);
        apb(1'b1, OFF_PIN_LEVELS, 32'h5A);
        rd_chk(OFF_OUTPUT_LATCH, 32'h5A);
        settle(2);
        chk(32'(pin_o & 8'hF0), 32'h50);
        $display("test gpio done");
    endtask : t_gpio

    task automatic t_slave;
        apb(1'b1, OFF_PORT_E_DIR, 32'h17);
        // host starts driving on the same edge that the port lets go of the upper pins
        @(posedge clock_i);
        host_data <= 8'hC3;
        host_oe <= 8'hFF;
        settle(2);
        chk(32'(slave_port_enable_o), 32'h1);
        chk(32'(pin_oe_o), 32'h0);
        chk(32'(port_e_direction_o), 32'h7);
        rd_chk(OFF_PIN_LEVELS, 32'hC3);
        @(posedge clock_i);
        host_oe <= 8'h00;
        slave_read <= 1'b1;
        settle(2);
        chk(32'(pin_oe_o), 32'hFF);
        chk(32'(pin_o), 32'h5A);
        @(posedge clock_i);
        slave_read <= 1'b0;
        apb(1'b1, OFF_PORT_E_DIR, 32'h07);
        settle(2);
        chk(32'(slave_port_enable_o), 32'h0);
        chk(32'(pin_oe_o), 32'hF0);
        $display("test slave done");
    endtask : t_slave

    task automatic t_pwm;
        apb(1'b1, OFF_PORT_E_DIR, 32'h17);
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, OFF_PWM_CTRL, 32'({2'(c), 6'h0C}));
            settle(1);
            chk(32'(slave_port_enable_o), 32'(c == 0));
        end
        @(posedge clock_i);
        pwm <= '{level: 3'b101, shutdown: 1'b0};
        slave_read <= 1'b1;
        apb(1'b1, OFF_PWM_CTRL, 32'h4C);
        settle(2);
        chk(32'(pwm_capture_control_o), 32'h4C);
        chk(32'(pin_o[7:5]), 32'h5);
        chk(32'(pin_oe_o[7:5]), 32'h7);
        @(posedge clock_i);
        pwm <= '{level: 3'b101, shutdown: 1'b1};
        settle(2);
        chk(32'(pin_oe_o[7:5]), 32'h7);
        apb(1'b1, OFF_PWM_PIN_CFG, 32'h1);
        settle(2);
        chk(32'(pin_oe_o[7:5]), 32'h0);
        rd_chk(OFF_PWM_PIN_CFG, 32'h1);
        @(posedge clock_i);
        pwm <= '0;
        slave_read <= 1'b0;
        apb(1'b1, OFF_PWM_CTRL, 32'h0);
        apb(1'b1, OFF_PORT_E_DIR, 32'h07);
        $display("test pwm done");
    endtask : t_pwm

    task automatic t_status;
        @(posedge clock_i);
        in_full <= 1'b1;
        overflow <= 1'b1;
        @(posedge clock_i);
        overflow <= 1'b0;
        rd_chk(OFF_PORT_E_DIR, 32'hA7);
        apb(1'b1, OFF_PORT_E_DIR, 32'h07);
        rd_chk(OFF_PORT_E_DIR, 32'h87);
        @(posedge clock_i);
        in_full <= 1'b0;
        out_full <= 1'b1;
        rd_chk(OFF_PORT_E_DIR, 32'h47);
        $display("test status done");
    endtask : t_status

    task automatic end_sim;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    initial begin
        #(40 * 5000);
        fails++;
        end_sim();
    end

    initial begin
        repeat (20) @(posedge clock_i);
        reset_i <= 1'b0;
        settle(1);
        t_reset();
        t_gpio();
        t_slave();
        t_pwm();
        t_status();
        end_sim();
    end
endmodule : bpd_port_tb
